// [logic/pls_consts.vh]
/*
 * Constants for the power-loss supervisor controller: register map,
 * field positions, reset values, state codes and AXI response codes.
 * Assumes inclusion by bare name from the logic/ folder.
 */
//
// Contract
// [R1] Enable low at power valid keeps disabled
// [R2] Enable rising moves disabled to soft-start
// [R3] Enable drop enters backup, then disabled
// [R4] Input switch closes: enable high, above reference
// [R5] Closed switch opens on over/undervoltage
// [R6] OV select zero disables, others thresholds
// [R7] Storage enable gates storage switch, converters
// [R8] Host holds storage enable low at startup
// [R9] Unmasked status change asserts interrupt low
// [R10] Each status source has own mask
// [R11] Interrupt holds until status read
// [R12] Listed interrupt sources all included
// [R13] Power-loss flag high after soft-start
// [R14] Power-loss flag drops entering backup
// [R15] Drain switch on in power-on hold
// [R16] Force bit turns drain switch on
// [R17] Storage-good follows regulation and 95 percent
// [R18] Storage-good low when converter disabled
// [R19] Output-good high once switch fully on
// [R20] Backup output-good falls on low feedback
// [R21] Input switch connects normally, opens backup
// [R22] Host holds storage enable high normally
// [R23] Source select: pin or register bit
// [R24] Backup also on OV, OC, difference
// [R25] Encoded readable state register
`ifndef PLS_CONSTS_VH
`define PLS_CONSTS_VH

// Register byte addresses
`define REG_STATE 4'h0
`define REG_STATUS 4'h4
`define REG_MASK 4'h8
`define REG_CTRL 4'hc

// Status bit positions, 14 sources
`define NSRC 14
`define ST_IN_OV 0
`define ST_IN_UV 1
`define ST_THERM_WARN 2
`define ST_THERM_SD 3
`define ST_DIFF 4
`define ST_CUR_WARN 5
`define ST_CUR_LIM 6
`define ST_NODE_BAD 7
`define ST_STR_OV 8
`define ST_STR_UV 9
`define ST_BACKUP 10
`define ST_BUCK_FLT 11
`define ST_BUCK_UV 12
`define ST_REF_UV 13

// Control register fields
`define CT_OVSEL_LO 0
`define CT_OVSEL_HI 2
`define CT_SRC_SEL 3
`define CT_SW_EN 4
`define CT_DRAIN 5
`define CT_W 6

// Reset values
`define CTRL_RST 6'h03
`define MASK_RST 14'h0000
`define OVSEL_OFF 3'h0

// State codes, one-hot
`define S_HOLD 6'h01
`define S_OFF 6'h02
`define S_SOFT 6'h04
`define S_NORM 6'h08
`define S_BACK 6'h10
`define S_INHIB 6'h20

// AXI responses
`define RESP_OK 2'h0
`define RESP_ERR 2'h2

`endif

// [logic/sync2.v]
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes inputs are quasi-static relative to aclk.
 */
`timescale 1ns/100ps
module sync2 #(
	parameter W = 1
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Data
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);
reg [W-1:0] meta_q;

// Two stages, first read only by second
always @(posedge aclk) begin
	if (!aresetn) begin
		meta_q <= {W{1'b0}};
		dout <= {W{1'b0}};
	end else begin
		meta_q <= din;
		dout <= meta_q;
	end
end
endmodule // sync2

// [logic/power_loss_supervisor_ctrl.v]
/*
 * Power-loss supervisor control: state sequencer, input and storage
 * switch control, power flags, interrupt with clear-on-read status,
 * drain switch, AXI4-Lite register slave.
 * Assumes analog comparators arrive as asynchronous levels.
 */
`timescale 1ns/100ps
`include "pls_consts.vh"
module power_loss_supervisor_ctrl (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Control pins
	input wire enable_pin,
	input wire storage_path_enable_pin,
	input wire input_power_valid,
	// Input-sense comparators
	input wire input_sense_above_uv,
	input wire [6:0] input_sense_above_ov,
	input wire input_overcurrent,
	input wire input_diff_high,
	// Converter and analog status
	input wire softstart_done,
	input wire switch_fully_on,
	input wire storage_in_reg,
	input wire storage_below_95,
	input wire storage_depleted,
	input wire buck_feedback_low,
	input wire therm_warn,
	input wire therm_sd,
	input wire cur_warn,
	input wire node_bad,
	input wire str_ov,
	input wire str_uv,
	input wire buck_flt,
	input wire buck_uv,
	input wire ref_uv,
	// Switch and converter enables
	output reg input_switch_on,
	output reg storage_switch_on,
	output reg buck_on,
	output reg boost_on,
	output reg storage_drain_pin,
	// Flags
	output reg power_loss_flag,
	output reg storage_good_flag,
	output reg output_good_flag,
	output reg fault_alert_n
);
localparam NI = 28;

wire [NI-1:0] raw_w;
wire [NI-1:0] pin_w;
reg [5:0] state_q;
reg [5:0] state_d;
reg [`NSRC-1:0] status_q;
reg [`NSRC-1:0] prev_q;
reg [`NSRC-1:0] latch_q;
reg [`NSRC-1:0] mask_q;
reg [`CT_W-1:0] ctrl_q;
reg en_prev_q;
reg [`NSRC-1:0] cur_w;
reg [`NSRC-1:0] chg_w;
reg ov_hit_w;
reg fault_w;
reg path_en_w;
reg aw_ok_q;
reg w_ok_q;
reg [3:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg rd_status_w;

// Gather asynchronous pins
assign raw_w = {enable_pin, storage_path_enable_pin, input_power_valid,
	input_sense_above_uv, input_sense_above_ov, input_overcurrent,
	input_diff_high, softstart_done, switch_fully_on, storage_in_reg,
	storage_below_95, storage_depleted, buck_feedback_low, therm_warn,
	therm_sd, cur_warn, node_bad, str_ov, str_uv, buck_flt, buck_uv,
	ref_uv};

sync2 #(.W(NI)) u_sync (
	.aclk(aclk),
	.aresetn(aresetn),
	.din(raw_w),
	.dout(pin_w)
);

wire en_s = pin_w[27];
wire path_pin_s = pin_w[26];
wire pwr_s = pin_w[25];
wire uv_ok_s = pin_w[24];
wire [6:0] ov_s = pin_w[23:17];
wire oc_s = pin_w[16];
wire diff_s = pin_w[15];
wire ss_done_s = pin_w[14];
wire full_on_s = pin_w[13];
wire in_reg_s = pin_w[12];
wire below95_s = pin_w[11];
wire depl_s = pin_w[10];
wire fb_low_s = pin_w[9];
wire [2:0] ovsel_w = ctrl_q[`CT_OVSEL_HI:`CT_OVSEL_LO];

// Overvoltage select and input fault terms
always @* begin
	ov_hit_w = 1'b0;
	if (ovsel_w != `OVSEL_OFF) begin // see [R6]
		ov_hit_w = ov_s[ovsel_w - 3'h1];
	end
	fault_w = ov_hit_w | ~uv_ok_s | oc_s | diff_s; // see [R5] see [R24]
	if (ctrl_q[`CT_SRC_SEL]) begin // see [R23]
		path_en_w = ctrl_q[`CT_SW_EN];
	end else begin
		path_en_w = path_pin_s;
	end
end

// Next state
always @* begin
	state_d = state_q;
	case (state_q)
	`S_HOLD: begin
		if (pwr_s) begin
			state_d = `S_OFF;
		end
	end
	`S_OFF: begin
		if (!pwr_s) begin
			state_d = `S_HOLD;
		end else if (en_s && !en_prev_q) begin // see [R1] see [R2]
			state_d = `S_SOFT;
		end
	end
	`S_SOFT: begin
		// Switch already closed here, so a drop falls back on storage
		if (!en_s || fault_w) begin // see [R3] see [R5]
			state_d = `S_BACK;
		end else if (ss_done_s) begin
			state_d = `S_INHIB;
		end
	end
	`S_NORM, `S_INHIB: begin
		if (!en_s || fault_w) begin // see [R3] see [R5] see [R24]
			state_d = `S_BACK;
		end else if (state_q == `S_INHIB && path_en_w && in_reg_s) begin
			state_d = `S_NORM;
		end else if (state_q == `S_NORM && !path_en_w) begin
			state_d = `S_INHIB;
		end
	end
	`S_BACK: begin
		if (depl_s) begin // see [R3]
			state_d = pwr_s ? `S_OFF : `S_HOLD;
		end else if (en_s && !fault_w) begin
			state_d = `S_SOFT;
		end
	end
	default: begin
		state_d = `S_HOLD;
	end
	endcase
end

// State register and enable edge memory
always @(posedge aclk) begin
	if (!aresetn) begin
		state_q <= `S_HOLD;
		en_prev_q <= 1'b1;
	end else begin
		state_q <= state_d; // see [R25]
		en_prev_q <= en_s;
	end
end

// Switch, converter and flag outputs from next state
always @(posedge aclk) begin
	if (!aresetn) begin
		input_switch_on <= 1'b0;
		storage_switch_on <= 1'b0;
		buck_on <= 1'b0;
		boost_on <= 1'b0;
		storage_drain_pin <= 1'b0;
		power_loss_flag <= 1'b0;
		storage_good_flag <= 1'b0;
		output_good_flag <= 1'b0;
	end else begin
		// Input switch closes only with enable high and input above undervoltage
		input_switch_on <= (state_d == `S_SOFT || state_d == `S_NORM ||
			state_d == `S_INHIB) && en_s && uv_ok_s; // see [R4] see [R21]
		storage_switch_on <= path_en_w && (state_d == `S_NORM ||
			state_d == `S_INHIB || state_d == `S_BACK); // see [R7] see [R22]
		boost_on <= path_en_w && state_d == `S_NORM; // see [R7]
		buck_on <= path_en_w && state_d == `S_BACK; // see [R7]
		storage_drain_pin <= (state_d == `S_HOLD) ||
			ctrl_q[`CT_DRAIN]; // see [R15] see [R16]
		power_loss_flag <= state_d == `S_NORM ||
			state_d == `S_INHIB; // see [R13] see [R14]
		// Storage good: regulation, drop at 95, converters off
		if (!path_en_w || state_d != `S_NORM) begin
			storage_good_flag <= 1'b0; // see [R18]
		end else if (below95_s) begin
			storage_good_flag <= 1'b0; // see [R17]
		end else if (in_reg_s) begin
			storage_good_flag <= 1'b1; // see [R17]
		end
		// Output good: switch fully on, held in backup until low feedback
		if (state_d == `S_BACK) begin
			if (state_q != `S_BACK) begin
				output_good_flag <= 1'b1; // see [R20]
			end else if (fb_low_s) begin
				output_good_flag <= 1'b0; // see [R20]
			end
		end else if (state_d == `S_NORM || state_d == `S_INHIB) begin
			output_good_flag <= full_on_s; // see [R19]
		end else begin
			output_good_flag <= 1'b0;
		end
	end
end

// Current status vector and change detect
always @* begin
	cur_w = {pin_w[0], pin_w[1], pin_w[2], state_q == `S_BACK,
		pin_w[3], pin_w[4], pin_w[5], oc_s, pin_w[6], diff_s,
		pin_w[7], pin_w[8], ~uv_ok_s, ov_hit_w}; // see [R12]
	chg_w = (cur_w ^ prev_q) & ~mask_q; // see [R9] see [R10]
end

// Read handshake of the status register
always @* begin
	rd_status_w = s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == `REG_STATUS;
end

// Latched changes, cleared on read unless still active or set again
always @(posedge aclk) begin
	if (!aresetn) begin
		status_q <= {`NSRC{1'b0}};
		prev_q <= {`NSRC{1'b0}};
		latch_q <= {`NSRC{1'b0}};
		fault_alert_n <= 1'b1;
	end else begin
		status_q <= cur_w;
		prev_q <= cur_w;
		if (rd_status_w) begin // see [R11]
			latch_q <= chg_w | (cur_w & ~mask_q);
		end else begin
			latch_q <= latch_q | chg_w;
		end
		fault_alert_n <= ~(|(rd_status_w ? (chg_w | (cur_w & ~mask_q)) :
			(latch_q | chg_w))); // see [R9] see [R11]
	end
end

// AXI write path: take address and data in either order
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OK;
		aw_ok_q <= 1'b0;
		w_ok_q <= 1'b0;
		awaddr_q <= 4'h0;
		wdata_q <= 32'h0000_0000;
		wstrb_q <= 4'h0;
		ctrl_q <= `CTRL_RST;
		mask_q <= `MASK_RST;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_ok_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_ok_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		// Commit once both halves are held
		if (aw_ok_q && w_ok_q && !s_axi_bvalid) begin
			aw_ok_q <= 1'b0;
			w_ok_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `RESP_OK;
			if (awaddr_q == `REG_MASK) begin
				if (wstrb_q[0]) begin
					mask_q[7:0] <= wdata_q[7:0]; // see [R10]
				end
				if (wstrb_q[1]) begin
					mask_q[`NSRC-1:8] <= wdata_q[`NSRC-1:8];
				end
			end else if (awaddr_q == `REG_CTRL) begin
				if (wstrb_q[0]) begin
					ctrl_q <= wdata_q[`CT_W-1:0]; // see [R16] see [R23]
				end
			end else if (awaddr_q == `REG_STATE ||
				awaddr_q == `REG_STATUS) begin
				s_axi_bresp <= `RESP_OK;
			end else begin
				s_axi_bresp <= `RESP_ERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// AXI read path
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `RESP_OK;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OK;
			if (s_axi_araddr == `REG_STATE) begin
				s_axi_rdata <= {26'h000_0000, state_q}; // see [R25]
			end else if (s_axi_araddr == `REG_STATUS) begin
				s_axi_rdata <= {2'h0, latch_q | chg_w,
					2'h0, status_q};
			end else if (s_axi_araddr == `REG_MASK) begin
				s_axi_rdata <= {18'h0_0000, mask_q};
			end else if (s_axi_araddr == `REG_CTRL) begin
				s_axi_rdata <= {26'h000_0000, ctrl_q};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `RESP_ERR;
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end
endmodule // power_loss_supervisor_ctrl

// [tb/pls_props.sv]
/* Port assertions for the supervisor control block.
   Bound to its top module; one clock, sync active-low reset. */
`timescale 1ns/100ps
module pls_props (
	// Clock, reset, read address
	input logic aclk,
	input logic aresetn,
	input logic [3:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	// Pins
	input logic enable_pin,
	input logic storage_path_enable_pin,
	input logic input_sense_above_uv,
	input logic softstart_done,
	// Outputs
	input logic input_switch_on,
	input logic storage_switch_on,
	input logic buck_on,
	input logic boost_on,
	input logic storage_drain_pin,
	input logic power_loss_flag,
	input logic storage_good_flag,
	input logic fault_alert_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Status read accepted
	wire rd_st = s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h4;
	sequence uv_low;
		!input_sense_above_uv [*5];
	endsequence
	sequence path_low;
		!storage_path_enable_pin [*5];
	endsequence
	drain_hold_a: assert property (
		$rose(aresetn) |-> ##[1:2] storage_drain_pin)
		else $error("drain off after reset");
	plf_rise_a: assert property (
		$rose(power_loss_flag) |-> softstart_done)
		else $error("loss flag rose early");
	plf_switch_a: assert property (
		power_loss_flag |-> input_switch_on)
		else $error("loss flag high with switch open");
	switch_cond_a: assert property (
		$rose(input_switch_on) |-> enable_pin && input_sense_above_uv)
		else $error("switch closed without enable");
	uv_open_a: assert property (
		uv_low |-> !input_switch_on)
		else $error("switch closed under undervoltage");
	path_off_a: assert property (
		path_low |-> !(storage_switch_on || buck_on || boost_on))
		else $error("storage path on while disabled");
	good_off_a: assert property (
		path_low |-> !storage_good_flag)
		else $error("storage good with path off");
	alert_hold_a: assert property (
		$rose(fault_alert_n) |-> $past(rd_st) || $past(rd_st, 2)
			|| $past(rd_st, 3))
		else $error("alert cleared without status read");
endmodule // pls_props

bind power_loss_supervisor_ctrl pls_props i_props (.aclk, .aresetn,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .enable_pin,
	.storage_path_enable_pin, .input_sense_above_uv, .softstart_done,
	.input_switch_on, .storage_switch_on, .buck_on, .boost_on,
	.storage_drain_pin, .power_loss_flag, .storage_good_flag,
	.fault_alert_n);

// [tb/host_model.sv]
/* Host side: drives the storage-path enable.
   Assumes the bench says when system boot is over. */
`timescale 1ns/100ps
module host_model (
	// Clock
	input logic aclk,
	// Boot finished
	input logic boot_done,
	// To the device
	output logic storage_path_enable_pin
);
	// Low through boot, high after it
	initial storage_path_enable_pin = 1'b0;
	always @(posedge aclk) begin
		storage_path_enable_pin <= boot_done;
	end
endmodule // host_model

// [tb/testbench.sv]
/* Self-checking bench for the supervisor control block.
   Drives AXI4-Lite and pin levels; host model owns storage enable. */
`timescale 1ns/100ps
module testbench;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic enable_pin = 1'b0, input_power_valid = 1'b0, boot = 1'b0;
	logic input_sense_above_uv = 1'b0, softstart_done = 1'b0;
	logic switch_fully_on = 1'b0, storage_in_reg = 1'b0;
	logic storage_depleted = 1'b0, buck_feedback_low = 1'b0;
	logic storage_below_95 = 1'b0;
	logic [6:0] input_sense_above_ov = 7'h00;
	logic [10:0] misc = 11'h000;
	logic storage_path_enable_pin, input_switch_on, storage_switch_on;
	logic buck_on, boost_on, storage_drain_pin, power_loss_flag;
	logic storage_good_flag, output_good_flag, fault_alert_n;
	int err_total = 0, samples_checked = 0;
	int pos [11] = '{2, 3, 5, 7, 8, 9, 11, 12, 13, 4, 6};

	// Clock, 50 ns period
	always #25 aclk = ~aclk;

	host_model i_host (.aclk, .boot_done(boot), .storage_path_enable_pin);

	power_loss_supervisor_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready(1'b1), .enable_pin, .storage_path_enable_pin,
		.input_power_valid, .input_sense_above_uv, .input_sense_above_ov,
		.input_overcurrent(misc[10]), .input_diff_high(misc[9]),
		.softstart_done, .switch_fully_on, .storage_in_reg,
		.storage_below_95,
		.storage_depleted, .buck_feedback_low, .therm_warn(misc[0]),
		.therm_sd(misc[1]), .cur_warn(misc[2]), .node_bad(misc[3]),
		.str_ov(misc[4]), .str_uv(misc[5]), .buck_flt(misc[6]),
		.buck_uv(misc[7]), .ref_uv(misc[8]), .input_switch_on,
		.storage_switch_on, .buck_on, .boost_on, .storage_drain_pin,
		.power_loss_flag, .storage_good_flag, .output_good_flag,
		.fault_alert_n);

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// Write one word, expect a response code
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask

	// Read one word into rv
	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rv = s_axi_rdata;
		chk("rresp", 32'h0, 32'(s_axi_rresp));
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (4000) @(posedge aclk);
		err_total++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0001, rv);
		rd(4'hc);
		chk("ctrl", 32'h0000_0003, rv & 32'h0000_003f);
		chk("drain", 32'h1, 32'(storage_drain_pin));
		wr(4'h2, 32'h0000_0000, 2'h2);
		wr(4'h8, 32'h0000_3fff, 2'h0);
		$display("end of reset test");
		input_power_valid <= 1'b1;
		input_sense_above_uv <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0002, rv);
		chk("switch", 32'h0, 32'(input_switch_on));
		enable_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0004, rv);
		softstart_done <= 1'b1;
		switch_fully_on <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("switch", 32'h1, 32'(input_switch_on));
		chk("loss", 32'h1, 32'(power_loss_flag));
		chk("outgood", 32'h1, 32'(output_good_flag));
		boot <= 1'b1;
		storage_in_reg <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0008, rv);
		chk("storsw", 32'h1, 32'(storage_switch_on));
		chk("boost", 32'h1, 32'(boost_on));
		chk("storgood", 32'h1, 32'(storage_good_flag));
		storage_below_95 <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("storgood", 32'h0, 32'(storage_good_flag));
		storage_below_95 <= 1'b0;
		wr(4'hc, 32'h0000_000b, 2'h0);
		repeat (4) @(posedge aclk);
		chk("storsw", 32'h0, 32'(storage_switch_on));
		chk("boost", 32'h0, 32'(boost_on));
		chk("storgood", 32'h0, 32'(storage_good_flag));
		wr(4'hc, 32'h0000_001b, 2'h0);
		repeat (6) @(posedge aclk);
		chk("storsw", 32'h1, 32'(storage_switch_on));
		$display("end of startup test");
		wr(4'hc, 32'h0000_0000, 2'h0);
		input_sense_above_ov <= 7'h7f;
		repeat (8) @(posedge aclk);
		chk("loss", 32'h1, 32'(power_loss_flag));
		rd(4'h4);
		repeat (3) @(posedge aclk);
		chk("alert", 32'h1, 32'(fault_alert_n));
		wr(4'h8, 32'h0000_3bff, 2'h0);
		wr(4'hc, 32'h0000_0003, 2'h0);
		repeat (8) @(posedge aclk);
		chk("loss", 32'h0, 32'(power_loss_flag));
		chk("switch", 32'h0, 32'(input_switch_on));
		chk("buck", 32'h1, 32'(buck_on));
		chk("outgood", 32'h1, 32'(output_good_flag));
		chk("alert", 32'h0, 32'(fault_alert_n));
		rd(4'h4);
		chk("status", 32'h0000_0401, rv & 32'h0000_3fff);
		repeat (3) @(posedge aclk);
		chk("alert", 32'h0, 32'(fault_alert_n));
		wr(4'h8, 32'h0000_3fff, 2'h0);
		rd(4'h4);
		repeat (3) @(posedge aclk);
		chk("alert", 32'h1, 32'(fault_alert_n));
		buck_feedback_low <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("outgood", 32'h0, 32'(output_good_flag));
		wr(4'hc, 32'h0000_0023, 2'h0);
		repeat (4) @(posedge aclk);
		chk("drain", 32'h1, 32'(storage_drain_pin));
		enable_pin <= 1'b0;
		storage_depleted <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0002, rv);
		$display("end of backup test");
		input_sense_above_ov <= 7'h00;
		foreach (pos[i]) begin
			misc <= 11'h001 << i;
			repeat (6) @(posedge aclk);
			rd(4'h4);
			chk("source", 32'h1 << pos[i], rv & 32'h0000_3fff);
		end
		$display("end of source test");
		misc <= 11'h000;
		storage_depleted <= 1'b0;
		enable_pin <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0008, rv);
		enable_pin <= 1'b0;
		repeat (6) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0010, rv);
		chk("loss", 32'h0, 32'(power_loss_flag));
		storage_depleted <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(4'h0);
		chk("state", 32'h0000_0002, rv);
		$display("end of enable test");
		report_and_stop();
	end
endmodule // testbench
